//--- src/cb_cfg_defs.svh
// offsets, field positions, reset values and fixed codes of the card bridge header registers
// Notes on behaviour
// R1: latency count restarts at frame, counts per clock
// R2: expired count ends own transfer once grant drops
// R3: header layout byte reads fixed 02h
// R4: header 0-7Fh, 80h-FFh go to extension
// R5: self-test byte reads fixed 00h
// R6: window base bits 31-12 read and write
// R7: window base bits 11-0 read zero
// R8: all ones written reads back FFFFF000h
// R9: socket regs at 000h, legacy set 800h
// R10: capability pointer reads fixed A0h
// R11: power management dwords at A0h, A4h
// R12: status bit clears on one, zero keeps
// R13: status mixes fixed and clearable, resets 0200h
// R14: latency field eight bits, unit one clock
// R15: bit 15 sets on card parity error
// R16: bit 13 sets on card master abort
// R17: bits 10-9 fixed 01b, medium timing
// R18: bit 8 needs parity, mastership, response enable
// R19: writes touch only enabled bytes, fixed bits kept
// R20: writable and sticky fields reset to defaults
`ifndef CB_CFG_DEFS_SVH
`define CB_CFG_DEFS_SVH

// dword addresses (byte address bits 7..2)
`define CB_DW_LATENCY       6'h03
`define CB_DW_WINDOW        6'h04
`define CB_DW_CAP_STATUS    6'h05
`define CB_DW_PM_FIRST      6'h28
`define CB_DW_PM_SECOND     6'h29
`define CB_EXT_FIRST_BYTE   8'h80

// register byte offsets
`define CB_OFF_LATENCY      8'h0D
`define CB_OFF_HEADER       8'h0E
`define CB_OFF_SELF_TEST    8'h0F
`define CB_OFF_WINDOW       8'h10
`define CB_OFF_CAP_PTR      8'h14
`define CB_OFF_STATUS       8'h16

// fixed and reset values
`define CB_LATENCY_RST      8'h00
`define CB_HEADER_CODE      8'h02
`define CB_SELF_TEST_CODE   8'h00
`define CB_CAP_PTR_CODE     8'hA0
`define CB_WINDOW_RST       32'h0000_0000
`define CB_WINDOW_MASK      32'hFFFF_F000
`define CB_STATUS_RST       16'h0200

// status field positions
`define CB_ST_PARITY        15
`define CB_ST_SERR          14
`define CB_ST_MABORT        13
`define CB_ST_TABT_RX       12
`define CB_ST_TABT_SIG      11
`define CB_ST_DPAR          8
`define CB_ST_TIMING_LO     9
`define CB_ST_TIMING_CODE   2'h1
`define CB_ST_CLEAR_MASK    16'hF900

// window map
`define CB_WIN_LEGACY_BIT   11
`define CB_WIN_LEGACY_OFF   12'h800
`define CB_WIN_SOCKET_OFF   12'h000

`endif

//--- src/cb_cfg_pkg.sv
// types shared by the card bridge header register files
package cb_cfg_pkg;
    typedef enum logic [1:0] {
        region_header = 2'b00,
        region_ext    = 2'b01,
        region_pm     = 2'b10
    } cfg_region_e;

    typedef logic [7:0] cfg_byte_t;
endpackage

//--- src/cb_latency_guard.sv
// initiator latency counter and forced end of own transfer
`timescale 1ns/1ns
`include "cb_cfg_defs.svh"
module cb_latency_guard
    import cb_cfg_pkg::*;
#(
    parameter int COUNT_W = 8
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    // programmed limit
    input  wire logic [COUNT_W-1:0] limit_i,
    // initiator state
    input  wire logic               frame_start_i,
    input  wire logic               master_active_i,
    input  wire logic               gnt_n_i,
    // results
    output logic                    expired_o,
    output logic                    master_stop_o
);
    initial begin
        if (COUNT_W != 8) begin
            $error("latency field is eight bits wide");
        end
    end

    logic [COUNT_W-1:0] count_reg;
    logic               gnt_n_meta_reg;
    logic               gnt_n_sync_reg;

    // grant arrives from the arbiter pin
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnt_n_meta_reg <= 1'b1;
            gnt_n_sync_reg <= 1'b1;
        end else begin
            gnt_n_meta_reg <= gnt_n_i;
            gnt_n_sync_reg <= gnt_n_meta_reg;
        end
    end

    // saturating so a long burst never wraps back under the limit
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else if (frame_start_i) begin
            count_reg <= '0; // R1
        end else if (master_active_i && (count_reg != {COUNT_W{1'b1}})) begin
            count_reg <= count_reg + 1'b1; // R1 R14
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            expired_o     <= 1'b0;
            master_stop_o <= 1'b0;
        end else begin
            expired_o     <= master_active_i && !frame_start_i && (count_reg >= limit_i); // R1
            master_stop_o <= master_active_i && !frame_start_i && (count_reg >= limit_i)
                             && gnt_n_sync_reg; // R2
        end
    end
endmodule

//--- src/cb_window_decode.sv
// memory window hit decode for socket and legacy register sets
`timescale 1ns/1ns
`include "cb_cfg_defs.svh"
module cb_window_decode
    import cb_cfg_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // window placement
    input  wire logic [ADDR_W-1:0] base_i,
    // memory access
    input  wire logic              mem_valid_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    // decode result
    output logic                   socket_hit_o,
    output logic                   legacy_hit_o,
    output logic [10:0]            window_offset_o
);
    initial begin
        if (ADDR_W != 32) begin
            $error("window decode serves a 32-bit memory space only");
        end
    end

    logic in_window;

    // a zero base is treated as unplaced so reset state claims nothing
    assign in_window = mem_valid_i && (base_i != '0) && (mem_addr_i[ADDR_W-1:12] == base_i[ADDR_W-1:12]);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            socket_hit_o    <= 1'b0;
            legacy_hit_o    <= 1'b0;
            window_offset_o <= '0;
        end else begin
            socket_hit_o    <= in_window && !mem_addr_i[`CB_WIN_LEGACY_BIT]; // R9
            legacy_hit_o    <= in_window && mem_addr_i[`CB_WIN_LEGACY_BIT]; // R9
            window_offset_o <= mem_addr_i[10:0];
        end
    end
endmodule

//--- src/cb_bridge_header_regs.sv
// card bridge configuration header registers 0Dh..17h with latency guard and window decode
`timescale 1ns/1ns
`include "cb_cfg_defs.svh"
module cb_bridge_header_regs
    import cb_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // configuration access
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_rvalid_o,
    output logic [31:0]      cfg_rdata_o,
    // extension space hand-off
    output logic             ext_sel_o,
    output logic             pm_sel_o,
    input  wire logic [31:0] ext_rdata_i,
    // card side events
    input  wire logic        card_parity_detected_i,
    input  wire logic        card_serr_i,
    input  wire logic        card_master_abort_received_i,
    input  wire logic        card_target_abort_received_i,
    input  wire logic        card_target_abort_signaled_i,
    input  wire logic        card_perr_i,
    input  wire logic        card_bus_master_i,
    input  wire logic        parity_response_en_i,
    // host side initiator
    input  wire logic        frame_start_i,
    input  wire logic        master_active_i,
    input  wire logic        gnt_n_i,
    output logic             latency_expired_o,
    output logic             master_stop_o,
    // memory window
    input  wire logic        mem_valid_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             socket_hit_o,
    output logic             legacy_hit_o,
    output logic [10:0]      window_offset_o,
    output logic [31:0]      window_base_o
);
    logic [7:0]  latency_timer_reg;
    logic [31:0] socket_window_base_reg;
    logic [15:0] card_side_status_reg;
    logic [15:0] status_set;
    logic [15:0] status_clr;
    logic [31:0] header_rdata;
    logic [31:0] rdata_next;
    logic [5:0]  dw_addr;
    cfg_region_e region;
    logic        wr_latency;
    logic        wr_window;
    logic        wr_status;

    assign dw_addr = cfg_addr_i[7:2];

    // header below 80h, device-specific space above
    always_comb begin
        if (cfg_addr_i < `CB_EXT_FIRST_BYTE) begin
            region = region_header; // R4
        end else if ((dw_addr == `CB_DW_PM_FIRST) || (dw_addr == `CB_DW_PM_SECOND)) begin
            region = region_pm; // R11
        end else begin
            region = region_ext; // R4
        end
    end

    assign ext_sel_o = (cfg_rd_i || cfg_wr_i) && (region != region_header); // R4
    assign pm_sel_o  = (cfg_rd_i || cfg_wr_i) && (region == region_pm); // R11

    assign wr_latency = cfg_wr_i && (region == region_header) && (dw_addr == `CB_DW_LATENCY);
    assign wr_window  = cfg_wr_i && (region == region_header) && (dw_addr == `CB_DW_WINDOW);
    assign wr_status  = cfg_wr_i && (region == region_header) && (dw_addr == `CB_DW_CAP_STATUS);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latency_timer_reg <= `CB_LATENCY_RST; // R20
        end else if (wr_latency && cfg_be_i[1]) begin
            latency_timer_reg <= cfg_wdata_i[15:8]; // R14 R19
        end
    end

    // one byte lane per generate step; low nibble of lane 1 and all of lane 0 stay zero
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_window_lane
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    socket_window_base_reg[lane*8 +: 8] <= 8'(`CB_WINDOW_RST >> (lane*8)); // R20
                end else if (wr_window && cfg_be_i[lane]) begin
                    socket_window_base_reg[lane*8 +: 8] <=
                        cfg_wdata_i[lane*8 +: 8] & 8'(`CB_WINDOW_MASK >> (lane*8)); // R6 R7 R8 R19
                end
            end
        end
    endgenerate

    assign window_base_o = socket_window_base_reg;

    always_comb begin
        status_set = '0;
        status_set[`CB_ST_PARITY]   = card_parity_detected_i; // R15
        status_set[`CB_ST_SERR]     = card_serr_i;
        status_set[`CB_ST_MABORT]   = card_master_abort_received_i; // R16
        status_set[`CB_ST_TABT_RX]  = card_target_abort_received_i;
        status_set[`CB_ST_TABT_SIG] = card_target_abort_signaled_i;
        status_set[`CB_ST_DPAR]     = card_perr_i && card_bus_master_i && parity_response_en_i; // R18
    end

    always_comb begin
        status_clr = '0;
        if (wr_status) begin
            status_clr[7:0]  = cfg_be_i[2] ? cfg_wdata_i[23:16] : 8'h00; // R19
            status_clr[15:8] = cfg_be_i[3] ? cfg_wdata_i[31:24] : 8'h00; // R19
        end
        status_clr = status_clr & `CB_ST_CLEAR_MASK; // R13
    end

    // an event in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            card_side_status_reg <= `CB_STATUS_RST; // R13 R20
        end else begin
            card_side_status_reg <= ((card_side_status_reg & ~status_clr) | status_set) & `CB_ST_CLEAR_MASK; // R12
            card_side_status_reg[`CB_ST_TIMING_LO +: 2] <= `CB_ST_TIMING_CODE; // R17
        end
    end

    always_comb begin
        header_rdata = 32'h0000_0000;
        unique case (dw_addr)
            `CB_DW_LATENCY: begin
                header_rdata[15:8]  = latency_timer_reg;
                header_rdata[23:16] = `CB_HEADER_CODE; // R3
                header_rdata[31:24] = `CB_SELF_TEST_CODE; // R5
            end
            `CB_DW_WINDOW: begin
                header_rdata = socket_window_base_reg & `CB_WINDOW_MASK; // R7
            end
            `CB_DW_CAP_STATUS: begin
                header_rdata[7:0]   = `CB_CAP_PTR_CODE; // R10
                header_rdata[31:16] = card_side_status_reg;
            end
            default: begin
                header_rdata = 32'h0000_0000;
            end
        endcase
    end

    assign rdata_next = (region == region_header) ? header_rdata : ext_rdata_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rvalid_o <= 1'b0;
            cfg_rdata_o  <= 32'h0000_0000;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= rdata_next;
            end
        end
    end

    cb_latency_guard #(
        .COUNT_W (8)
    ) u_latency_guard (
        .clk_sys_i       (clk_sys_i),
        .rst_n_i         (rst_n_i),
        .limit_i         (latency_timer_reg),
        .frame_start_i   (frame_start_i),
        .master_active_i (master_active_i),
        .gnt_n_i         (gnt_n_i),
        .expired_o       (latency_expired_o),
        .master_stop_o   (master_stop_o)
    );

    cb_window_decode #(
        .ADDR_W (32)
    ) u_window_decode (
        .clk_sys_i       (clk_sys_i),
        .rst_n_i         (rst_n_i),
        .base_i          (socket_window_base_reg),
        .mem_valid_i     (mem_valid_i),
        .mem_addr_i      (mem_addr_i),
        .socket_hit_o    (socket_hit_o),
        .legacy_hit_o    (legacy_hit_o),
        .window_offset_o (window_offset_o)
    );
endmodule

//--- sim/cb_bridge_header_regs_properties.sv
// concurrent checks on the card bridge header register ports
`timescale 1ns/1ns
module cb_bridge_header_regs_properties (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // configuration access
    input wire logic        cfg_rd_i,
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [31:0] ext_rdata_i,
    input wire logic        cfg_rvalid_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        ext_sel_o,
    input wire logic        pm_sel_o,
    // memory window
    input wire logic        mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic        socket_hit_o,
    input wire logic        legacy_hit_o,
    input wire logic [31:0] window_base_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic acc = cfg_rd_i || cfg_wr_i;
    wire logic in_win = mem_valid_i && window_base_o != 32'h0 && mem_addr_i[31:12] == window_base_o[31:12];

    id_bytes_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h03 |=> cfg_rdata_o[31:16] == 16'h0002)
        else $error("id bytes wrong");
    base_read_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h04 |=> cfg_rdata_o == window_base_o)
        else $error("base read differs");
    base_low_a: assert property (window_base_o[11:0] == 12'h000)
        else $error("base low bits set");
    cap_fixed_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h05 |=>
        cfg_rdata_o[23:0] == 24'h0000A0 && cfg_rdata_o[26:25] == 2'b01) else $error("fixed fields wrong");
    ext_sel_a: assert property (acc |-> ext_sel_o == cfg_addr_i[7])
        else $error("ext select wrong");
    pm_sel_a: assert property (acc |-> pm_sel_o == (cfg_addr_i[7:3] == 5'h14))
        else $error("pm select wrong");
    ext_data_a: assert property (cfg_rd_i && cfg_addr_i[7] |=> cfg_rvalid_o && cfg_rdata_o == $past(ext_rdata_i))
        else $error("ext data wrong");
    win_hit_a: assert property (in_win |=> legacy_hit_o == $past(mem_addr_i[11]) && socket_hit_o != legacy_hit_o)
        else $error("window hit wrong");
    read_pulse_a: assert property (cfg_rvalid_o |-> $past(cfg_rd_i))
        else $error("stray read answer");
endmodule

bind cb_bridge_header_regs cb_bridge_header_regs_properties i_props (.clk_sys_i, .rst_n_i, .cfg_rd_i, .cfg_wr_i,
    .cfg_addr_i, .ext_rdata_i, .cfg_rvalid_o, .cfg_rdata_o, .ext_sel_o, .pm_sel_o, .mem_valid_i, .mem_addr_i,
    .socket_hit_o, .legacy_hit_o, .window_base_o);

//--- sim/cfg_host_model.sv
// host configuration master issuing single-cycle read and write requests
`timescale 1ns/1ns
module cfg_host_model (
    // clock
    input  wire logic  clk_sys_i,
    // request lines
    output logic        cfg_rd_o = 1'b0,
    output logic        cfg_wr_o = 1'b0,
    output logic [7:0]  cfg_addr_o = 8'h00,
    output logic [3:0]  cfg_be_o = 4'h0,
    output logic [31:0] cfg_wdata_o = 32'h0
);
    // idle address, enable and data lines carry the inverse of the last request and both strobes drop low, so stale data never looks valid
    task automatic cycle(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys_i);
        cfg_rd_o    <= !wr;
        cfg_wr_o    <= wr;
        cfg_addr_o  <= a;
        cfg_be_o    <= be;
        cfg_wdata_o <= d;
        @(posedge clk_sys_i);
        cfg_rd_o    <= 1'b0;
        cfg_wr_o    <= 1'b0;
        cfg_addr_o  <= ~a;
        cfg_be_o    <= ~be;
        cfg_wdata_o <= ~d;
    endtask
endmodule

//--- sim/test_cb_bridge_header_regs.sv
// self-checking bench for the card bridge header registers
`timescale 1ns/1ns
module test_cb_bridge_header_regs;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        rd, wr, rv, frame = 0, act = 0, gnt_n = 1, expd, stop, mv = 0, sock, leg;
    logic [7:0]  ad, ev = 8'h00;
    logic [3:0]  be;
    logic [10:0] woff;
    logic [31:0] wd, rdat, ext = 32'h0, ma = 32'h0, wbase, base, seed = 32'hBD55;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          n_tests = 0;
    int          cnt;

    always #25 clk_sys_i = ~clk_sys_i;

    cfg_host_model i_host (.clk_sys_i, .cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_addr_o(ad), .cfg_be_o(be), .cfg_wdata_o(wd));
    cb_bridge_header_regs i_dut (.clk_sys_i, .rst_n_i, .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(ad), .cfg_be_i(be),
        .cfg_wdata_i(wd), .cfg_rvalid_o(rv), .cfg_rdata_o(rdat), .ext_sel_o(), .pm_sel_o(), .ext_rdata_i(ext),
        .card_parity_detected_i(ev[0]), .card_serr_i(ev[1]), .card_master_abort_received_i(ev[2]),
        .card_target_abort_received_i(ev[3]), .card_target_abort_signaled_i(ev[4]), .card_perr_i(ev[5]),
        .card_bus_master_i(ev[6]), .parity_response_en_i(ev[7]), .frame_start_i(frame), .master_active_i(act),
        .gnt_n_i(gnt_n), .latency_expired_o(expd), .master_stop_o(stop), .mem_valid_i(mv), .mem_addr_i(ma),
        .socket_hit_o(sock), .legacy_hit_o(leg), .window_offset_o(woff), .window_base_o(wbase));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        check(32'(exp_q.size()), 32'h0);
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        i_host.cycle(1'b0, a, 4'h0, 32'h0);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge clk_sys_i);
        ev <= v;
        @(posedge clk_sys_i);
        ev <= 8'h00;
    endtask
    task automatic mem(input logic [31:0] a, input logic [1:0] hit, input logic [10:0] off);
        @(posedge clk_sys_i);
        mv <= 1'b1;
        ma <= a;
        @(posedge clk_sys_i);
        mv <= 1'b0;
        ma <= ~a;
        #1;
        check({sock, leg}, hit);
        if (hit != 2'b00) check(woff, off);
    endtask
    task automatic wait_for(ref logic sig, input int lim);
        cnt = 0;
        while (sig !== 1'b1 && cnt < lim) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        if (cnt == lim) begin
            check(32'(cnt), 32'(lim - 1));
            wrap_up();
        end
    endtask

    // read answers are matched against notes in request order
    always @(posedge clk_sys_i) begin
        if (rv === 1'b1) begin
            check(32'(exp_q.size() != 0), 32'h1);
            if (exp_q.size() != 0) check(rdat, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd_exp(8'h0C, 32'h0002_0000);
        rd_exp(8'h10, 32'h0);
        rd_exp(8'h14, 32'h0200_00A0);
        rd_exp(8'h00, 32'h0);
        $display("reset values done");
        i_host.cycle(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        rd_exp(8'h0C, 32'h0002_FF00);
        i_host.cycle(1'b1, 8'h0C, 4'hD, 32'h0);
        rd_exp(8'h0C, 32'h0002_FF00);
        i_host.cycle(1'b1, 8'h0C, 4'h2, 32'h0000_0400);
        rd_exp(8'h0C, 32'h0002_0400);
        i_host.cycle(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        rd_exp(8'h10, 32'hFFFF_F000);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            i_host.cycle(1'b1, 8'h10, 4'hF, seed);
            rd_exp(8'h10, seed & 32'hFFFF_F000);
        end
        i_host.cycle(1'b1, 8'h10, 4'h4, 32'h0);
        rd_exp(8'h10, seed & 32'hFF00_F000);
        base = (seed | 32'h8000_0000) & 32'hFFFF_F000;
        i_host.cycle(1'b1, 8'h10, 4'hF, base);
        mem(base + 32'h004, 2'b10, 11'h004);
        mem(base + 32'h810, 2'b01, 11'h010);
        mem(base + 32'h1000, 2'b00, 11'h000);
        check(wbase, base);
        $display("window done");
        pulse(8'h1F);
        rd_exp(8'h14, 32'hFA00_00A0);
        pulse(8'h60);
        rd_exp(8'h14, 32'hFA00_00A0);
        pulse(8'hE0);
        rd_exp(8'h14, 32'hFB00_00A0);
        i_host.cycle(1'b1, 8'h14, 4'hD, 32'hA600_0055);
        rd_exp(8'h14, 32'h5B00_00A0);
        i_host.cycle(1'b1, 8'h14, 4'hC, 32'hFFFF_0000);
        rd_exp(8'h14, 32'h0200_00A0);
        seed = xs(seed);
        @(posedge clk_sys_i);
        ext <= seed;
        rd_exp(8'hC4, seed);
        rd_exp(8'hA4, seed);
        $display("status and extension done");
        @(posedge clk_sys_i);
        frame <= 1'b1;
        act   <= 1'b1;
        gnt_n <= 1'b0;
        @(posedge clk_sys_i);
        frame <= 1'b0;
        wait_for(expd, 20);
        check(32'(cnt >= 3 && cnt <= 6), 32'h1);
        repeat (6) @(posedge clk_sys_i);
        check(stop, 1'b0);
        gnt_n <= 1'b1;
        wait_for(stop, 8);
        gnt_n <= 1'b0;
        frame <= 1'b1;
        @(posedge clk_sys_i);
        frame <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(expd, 1'b0);
        act <= 1'b0;
        $display("latency done");
        repeat (4) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule
